/* logic/afr_axis_fault_reset_cmd.sv */
// Axis fault reset command block with an AXI4-Lite register slave.
// How it works
// R1: Start request rising edge begins fault clearing; busy held high meanwhile.
// R2: Busy drops in the same period that done or error rises.
// R3: Done rises when clearing completes, axis in standstill or disabled; a fault edge in that same period leaves the axis in error stop.
// R4: Done falls with start request; if start already low, one period only.
// R5: Invalid conditions raise error and load the matching fault code.
// R6: Error and fault code clear when start request falls.
// R7: Success with drive power enable high moves axis to standstill; a fault edge in the completing period gives error stop instead.
// R8: Success with drive power enable low moves axis to disabled; a fault edge in the completing period gives error stop instead.
// R9: A servo drive fault is cleared too, then axis returns to normal state.
// R10: A fault that cannot be reset gives error with code 122.
// R11: The host holds start until done or error, then lowers it.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "afr_defs.svh"

module afr_axis_fault_reset_cmd #(
   parameter int CLEAR_CYCLES = `AFR_CLEAR_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic axis_fault_in,
   input wire logic drive_fault_in,
   input wire logic not_resettable_in,
   output afr_pkg::afr_axis_type axis_state,
   output logic drive_fault_clear
);
   import afr_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [1:0] sync3_r;

   // Two stages for every pin; a third stage only for fault edge detection.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
         sync3_r <= 2'h0;
      end else begin
         sync1_r <= {not_resettable_in, drive_fault_in, axis_fault_in};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r[1:0];
      end
   end

   logic fault_event;
   logic cause_active;
   assign fault_event = |(sync2_r[1:0] & ~sync3_r);
   assign cause_active = sync2_r[0];

   // ----------------------------------------------------------------
   // Command sequencer and axis state
   // ----------------------------------------------------------------
   logic [1:0] ctrl_r;
   logic start_request;
   logic drive_power_enable;
   logic start_prev_r;
   logic start_prev_nxt;
   afr_state_type state_r;
   afr_state_type state_nxt;
   afr_axis_type axis_r;
   afr_axis_type axis_nxt;
   logic [7:0] code_r;
   logic [7:0] code_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic clr_r;
   logic clr_nxt;

   assign start_request = ctrl_r[`AFR_CTRL_START_BIT];
   assign drive_power_enable = ctrl_r[`AFR_CTRL_POWER_BIT];

   // Only an edge starts work, so a request held high after completion does not rerun it.
   always_comb begin
      state_nxt = state_r;
      axis_nxt = axis_r;
      code_nxt = code_r;
      cnt_nxt = cnt_r;
      clr_nxt = 1'b0;
      start_prev_nxt = start_request;
      case (state_r)
         AFR_IDLE: begin
            if (start_request && !start_prev_r) begin
               if (cause_active) begin
                  state_nxt = AFR_ERR; // R5
                  code_nxt = `AFR_CODE_CAUSE_ACTIVE; // R5
               end else begin
                  state_nxt = AFR_CLEAR; // R1
                  cnt_nxt = 16'(CLEAR_CYCLES - 1);
               end
            end
         end
         AFR_CLEAR: begin
            if (cnt_r != 16'h0) begin
               cnt_nxt = cnt_r - 16'h1;
            end else if (sync2_r[2]) begin
               state_nxt = AFR_ERR; // R10
               code_nxt = `AFR_CODE_NOT_RESETTABLE; // R10
            end else begin
               state_nxt = AFR_DONE; // R3
               clr_nxt = 1'b1; // R9
               axis_nxt = drive_power_enable ? AFR_AX_STANDSTILL : AFR_AX_DISABLED; // R7 R8
            end
         end
         AFR_DONE: begin
            if (!start_request) begin
               state_nxt = AFR_IDLE; // R4
            end
         end
         AFR_ERR: begin
            if (!start_request) begin
               state_nxt = AFR_IDLE; // R6
               code_nxt = `AFR_CODE_NONE; // R6
            end
         end
         default: begin
            state_nxt = AFR_IDLE;
         end
      endcase
      // A new fault always wins, even in the period where clearing completes.
      if (fault_event) begin
         axis_nxt = AFR_AX_ERRORSTOP;
      end else if (axis_r != AFR_AX_ERRORSTOP && state_nxt != AFR_DONE) begin
         axis_nxt = drive_power_enable ? AFR_AX_STANDSTILL : AFR_AX_DISABLED;
      end
   end

   // Sequencer registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= AFR_IDLE;
         axis_r <= AFR_AX_DISABLED;
         code_r <= `AFR_CODE_NONE;
         cnt_r <= 16'h0;
         clr_r <= 1'b0;
         start_prev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         axis_r <= axis_nxt;
         code_r <= code_nxt;
         cnt_r <= cnt_nxt;
         clr_r <= clr_nxt;
         start_prev_r <= start_prev_nxt;
      end
   end

   afr_status_type status;
   assign status.axis_state = axis_r;
   assign status.busy_flag = (state_r == AFR_CLEAR); // R1 R2
   assign status.done_flag = (state_r == AFR_DONE);
   assign status.error_flag = (state_r == AFR_ERR);
   assign axis_state = axis_r;
   assign drive_fault_clear = clr_r;

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   logic [1:0] ctrl_nxt;
   logic bvalid_r;
   logic bvalid_nxt;
   logic [1:0] bresp_r;
   logic [1:0] bresp_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_r;
   logic [1:0] rresp_nxt;
   logic wr_go;
   logic rd_go;

   // Word index of each register, since only address bits 3:2 are decoded.
   localparam logic [1:0] CTRL_IDX = 2'(`AFR_CTRL_OFS >> 2);
   localparam logic [1:0] STATUS_IDX = 2'(`AFR_STATUS_OFS >> 2);
   localparam logic [1:0] CODE_IDX = 2'(`AFR_CODE_OFS >> 2);

   // Address and data are taken together; this costs one cycle but needs no holding buffer.
   assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
   assign s_axi_wready = s_axi_awready;
   assign s_axi_arready = !rvalid_r;
   assign wr_go = s_axi_awready;
   assign rd_go = s_axi_arvalid && !rvalid_r;

   // Register decode for both directions.
   always_comb begin
      ctrl_nxt = ctrl_r;
      bvalid_nxt = bvalid_r && !s_axi_bready;
      bresp_nxt = bresp_r;
      rvalid_nxt = rvalid_r && !s_axi_rready;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (wr_go) begin
         bvalid_nxt = 1'b1;
         bresp_nxt = `AFR_RESP_OKAY;
         if (s_axi_awaddr[3:2] == CTRL_IDX) begin
            if (s_axi_wstrb[0]) begin
               ctrl_nxt = s_axi_wdata[1:0];
            end
         end else if (s_axi_awaddr[3:2] != STATUS_IDX &&
                      s_axi_awaddr[3:2] != CODE_IDX) begin
            bresp_nxt = `AFR_RESP_SLVERR;
         end
      end
      if (rd_go) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = `AFR_RESP_OKAY;
         case (s_axi_araddr[3:2])
            CTRL_IDX: rdata_nxt = {30'h0, ctrl_r};
            STATUS_IDX: rdata_nxt = {27'h0, status};
            CODE_IDX: rdata_nxt = {24'h0, code_r};
            default: begin
               rdata_nxt = 32'h0;
               rresp_nxt = `AFR_RESP_SLVERR;
            end
         endcase
      end
   end

   // Bus registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `AFR_CTRL_RESET;
         bvalid_r <= 1'b0;
         bresp_r <= `AFR_RESP_OKAY;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= `AFR_RESP_OKAY;
      end else begin
         ctrl_r <= ctrl_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_start_busy;
      (state_r == AFR_IDLE && start_request && !start_prev_r && !cause_active)
         |=> status.busy_flag [*2];
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("busy not raised on start"); // R1

   property p_busy_exit;
      $fell(status.busy_flag) |-> (status.done_flag || status.error_flag);
   endproperty
   a_busy_exit: assert property (p_busy_exit) else $error("busy fell without done or error"); // R2

   property p_done_axis;
      $rose(status.done_flag) |-> (axis_r == AFR_AX_STANDSTILL || axis_r == AFR_AX_DISABLED
                           || $past(fault_event));
   endproperty
   a_done_axis: assert property (p_done_axis) else $error("done with axis in fault"); // R3

   property p_done_pulse;
      (status.done_flag && !start_request) |=> !status.done_flag;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done outlived start"); // R4

   property p_err_code;
      status.error_flag |-> (code_r != `AFR_CODE_NONE);
   endproperty
   a_err_code: assert property (p_err_code) else $error("error without code"); // R5

   property p_err_clear;
      (status.error_flag && !start_request) |=> (!status.error_flag && code_r == `AFR_CODE_NONE);
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("error not cleared"); // R6

   property p_to_standstill;
      ($rose(status.done_flag) && $past(drive_power_enable) && !$past(fault_event))
         |-> axis_r == AFR_AX_STANDSTILL;
   endproperty
   a_to_standstill: assert property (p_to_standstill) else $error("axis not standstill"); // R7

   property p_to_disabled;
      ($rose(status.done_flag) && !$past(drive_power_enable) && !$past(fault_event))
         |-> axis_r == AFR_AX_DISABLED;
   endproperty
   a_to_disabled: assert property (p_to_disabled) else $error("axis not disabled"); // R8

   property p_drive_clear;
      $rose(status.done_flag) |-> drive_fault_clear ##1 !drive_fault_clear;
   endproperty
   a_drive_clear: assert property (p_drive_clear) else $error("drive clear pulse missing"); // R9

   property p_not_resettable;
      (status.busy_flag && cnt_r == 16'h0 && sync2_r[2])
         |=> (status.error_flag && code_r == `AFR_CODE_NOT_RESETTABLE);
   endproperty
   a_not_resettable: assert property (p_not_resettable) else $error("code 122 missing"); // R10

   c_done: cover property ($rose(status.done_flag));
   c_done_one: cover property ($rose(status.done_flag) && !start_request);
   c_err_nr: cover property ($rose(status.error_flag) && code_r == `AFR_CODE_NOT_RESETTABLE);
   c_err_cause: cover property ($rose(status.error_flag) && code_r == `AFR_CODE_CAUSE_ACTIVE);

endmodule

/* logic/afr_defs.svh */
// Offsets, field positions, reset values and timing counts of the axis fault reset block.
`ifndef AFR_DEFS_SVH
`define AFR_DEFS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define AFR_CTRL_OFS 4'h0
`define AFR_STATUS_OFS 4'h4
`define AFR_CODE_OFS 4'h8

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define AFR_CTRL_START_BIT 0
`define AFR_CTRL_POWER_BIT 1
`define AFR_CTRL_RESET 2'h0
`define AFR_RESP_OKAY 2'h0
`define AFR_RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// Fault codes
// ----------------------------------------------------------------
`define AFR_CODE_NONE 8'h00
`define AFR_CODE_CAUSE_ACTIVE 8'h01
`define AFR_CODE_NOT_RESETTABLE 8'h7a

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AFR_CLK_PERIOD_NS 5
`define AFR_CLEAR_TIME_NS 1000
`define AFR_CLEAR_CYCLES ((`AFR_CLEAR_TIME_NS + `AFR_CLK_PERIOD_NS - 1) / `AFR_CLK_PERIOD_NS)

`endif

/* logic/afr_pkg.sv */
// Types shared by the axis fault reset block.
package afr_pkg;

   typedef enum logic [1:0] {
      AFR_IDLE = 2'h0,
      AFR_CLEAR = 2'h1,
      AFR_DONE = 2'h3,
      AFR_ERR = 2'h2
   } afr_state_type;

   typedef enum logic [1:0] {
      AFR_AX_DISABLED = 2'h0,
      AFR_AX_STANDSTILL = 2'h1,
      AFR_AX_ERRORSTOP = 2'h2
   } afr_axis_type;

   typedef struct packed {
      afr_axis_type axis_state;
      logic error_flag;
      logic busy_flag;
      logic done_flag;
   } afr_status_type;

endpackage

/* tb/afr_drive_model.sv */
// Servo drive model that latches a fault until the block pulses its clear line.
`timescale 1ns/10ps
module afr_drive_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic trip,
   input wire logic drive_fault_clear,
   output logic drive_fault_in,
   output int n_clear
);
   // ----------------------------------------------------------------
   // Fault latch
   // ----------------------------------------------------------------
   // A real drive keeps its fault raised until told to clear, so a
   // block that never pulses the clear line leaves the axis stuck.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         drive_fault_in <= 1'b0;
         n_clear <= 0;
      end else if (drive_fault_clear) begin
         drive_fault_in <= 1'b0;
         n_clear <= n_clear + 1;
      end else if (trip) begin
         drive_fault_in <= 1'b1;
      end
   end
endmodule

/* tb/test_axis_fault_reset_handshake.sv */
// Self-checking bench for the axis fault reset block over its register bus.
`timescale 1ns/10ps
`include "afr_defs.svh"
module test_axis_fault_reset_handshake;
   import afr_pkg::*;
   localparam logic [3:0] CT = `AFR_CTRL_OFS;
   localparam logic [3:0] ST = `AFR_STATUS_OFS;
   localparam logic [3:0] CD = `AFR_CODE_OFS;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] awaddr = 4'h0;
   logic [3:0] araddr = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, dfin, dfclr;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, got;
   logic axf = 1'b0;
   logic nrs = 1'b0;
   logic trip = 1'b0;
   afr_axis_type ax;
   int n_clear;
   int n_mismatch = 0;
   int num_checks = 0;

   // Clock at 200 MHz.
   always #2.5 clk = ~clk;

   afr_axis_fault_reset_cmd #(.CLEAR_CYCLES(8)) dut_u (.clk(clk), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .axis_fault_in(axf),
      .drive_fault_in(dfin), .not_resettable_in(nrs), .axis_state(ax),
      .drive_fault_clear(dfclr));

   afr_drive_model drv_u (.clk(clk), .rst(rst), .trip(trip),
      .drive_fault_clear(dfclr), .drive_fault_in(dfin), .n_clear(n_clear));

   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   // Each task that drives a signal opens on a fresh edge so no signal is driven twice at once.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
      num_checks++;
      if (a !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, a);
      end
   endtask

   // Handshakes are judged on values read at the falling edge, which the next rising edge samples.
   task automatic axw(input logic [3:0] a, input logic [31:0] d);
      logic aw_ok;
      logic w_ok;
      logic b_ok;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_ok = 1'b0;
      while (!b_ok) begin
         @(negedge clk);
         aw_ok = awvalid && awready;
         w_ok = wvalid && wready;
         b_ok = bvalid;
         resp = bresp;
         @(posedge clk);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   // Only the watchdog ends a wait that never sees its answer.
   task automatic axr(input logic [3:0] a);
      logic ar_ok;
      logic r_ok;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_ok = 1'b0;
      while (!r_ok) begin
         @(negedge clk);
         ar_ok = arvalid && arready;
         r_ok = rvalid;
         got = rdata;
         resp = rresp;
         @(posedge clk);
         if (ar_ok) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   // Status word: axis state, then error, busy and done flags.
   function automatic logic [31:0] st(input afr_axis_type a, input logic [2:0] f);
      st = {27'h0, a, f};
   endfunction

   // Pins pass a two-flop synchroniser, so the pulse is held and allowed to settle.
   task automatic fault(input logic on_axis);
      @(posedge clk);
      if (on_axis) axf <= 1'b1;
      else trip <= 1'b1;
      repeat (2) @(posedge clk);
      axf <= 1'b0;
      trip <= 1'b0;
      repeat (4) @(posedge clk);
   endtask

   task automatic wait_idle;
      int i;
      for (i = 0; i < 40; i++) begin
         axr(ST);
         if (got[1] === 1'b0) break;
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      axr(ST);
      chk("reset status", st(AFR_AX_DISABLED, 3'h0), got);
      axr(CD);
      chk("reset code", 32'h0, got);
      axr(4'hc);
      chk("unmapped rresp", 32'h2, {30'h0, resp});
      axw(4'hc, 32'h1);
      chk("unmapped bresp", 32'h2, {30'h0, resp});
      // Drive fault cleared with power enabled.
      axw(CT, 32'h2);
      fault(1'b0);
      axr(ST);
      chk("tripped", st(AFR_AX_ERRORSTOP, 3'h0), got);
      chk("axis pin trip", {30'h0, AFR_AX_ERRORSTOP}, {30'h0, ax});
      axw(CT, 32'h3);
      axr(ST);
      chk("busy", st(AFR_AX_ERRORSTOP, 3'h2), got);
      wait_idle;
      chk("done", st(AFR_AX_STANDSTILL, 3'h1), got);
      chk("clear pulses", 32'd1, n_clear);
      chk("axis pin done", {30'h0, AFR_AX_STANDSTILL}, {30'h0, ax});
      chk("drive fault", 32'h0, {31'h0, dfin});
      axw(CT, 32'h2);
      axr(ST);
      chk("done drop", st(AFR_AX_STANDSTILL, 3'h0), got);
      // Power off, start dropped while still busy: done lasts one period.
      axw(CT, 32'h0);
      fault(1'b1);
      axw(CT, 32'h1);
      axw(CT, 32'h0);
      wait_idle;
      chk("short done", st(AFR_AX_DISABLED, 3'h0), got);
      chk("axis pin off", {30'h0, AFR_AX_DISABLED}, {30'h0, ax});
      chk("clear pulses", 32'd2, n_clear);
      // A fault that cannot be reset.
      axw(CT, 32'h2);
      nrs <= 1'b1;
      fault(1'b1);
      axw(CT, 32'h3);
      wait_idle;
      chk("stuck", st(AFR_AX_ERRORSTOP, 3'h4), got);
      axr(CD);
      chk("stuck code", 32'd122, got);
      axw(CT, 32'h2);
      nrs <= 1'b0;
      axr(ST);
      chk("error drop", st(AFR_AX_ERRORSTOP, 3'h0), got);
      axr(CD);
      chk("code drop", 32'h0, got);
      // Fault cause still present at start.
      axf <= 1'b1;
      repeat (4) @(posedge clk);
      axw(CT, 32'h3);
      axr(ST);
      chk("cause", st(AFR_AX_ERRORSTOP, 3'h4), got);
      axr(CD);
      chk("cause code", {24'h0, `AFR_CODE_CAUSE_ACTIVE}, got);
      axw(CT, 32'h2);
      print_verdict;
   end

   // Whole sequence needs well under a thousand cycles.
   initial begin
      #100000;
      n_mismatch++;
      print_verdict;
   end
endmodule
